// File: hdl/timer_regs.svh
// Register offsets, field positions, reset values and timing counts of the dual timer/counter.
// Assumes an 8-bit special-function register space addressed by the processor core.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Register offsets
`define TMR_CTRL_ADDR    8'h88
`define TMR_MODE_ADDR    8'h89
`define TMR_LOW_A_ADDR   8'h8A
`define TMR_LOW_B_ADDR   8'h8B
`define TMR_HIGH_A_ADDR  8'h8C
`define TMR_HIGH_B_ADDR  8'h8D
`define TMR_RATE_ADDR    8'h8E

// Control register fields
`define CTRL_OVF_B       7
`define CTRL_RUN_B       6
`define CTRL_OVF_A       5
`define CTRL_RUN_A       4
`define CTRL_EXT_B       3
`define CTRL_TYPE_B      2
`define CTRL_EXT_A       1
`define CTRL_TYPE_A      0

// Mode register fields
`define MODE_GATE_B      7
`define MODE_CT_B        6
`define MODE_SEL_B_HI    5
`define MODE_SEL_B_LO    4
`define MODE_GATE_A      3
`define MODE_CT_A        2
`define MODE_SEL_A_HI    1
`define MODE_SEL_A_LO    0

// Rate register fields
`define RATE_SEL_B       4
`define RATE_SEL_A       3

// Reset values
`define TMR_CTRL_RESET   8'h00
`define TMR_MODE_RESET   8'h00
`define TMR_RATE_RESET   8'h01
`define TMR_COUNT_RESET  8'h00

// Clocks per timer increment
`define TMR_DIV_SLOW     12
`define TMR_DIV_FAST     4

`endif

// File: hdl/timer_pkg.sv
// Types shared by the dual timer/counter files.
// Assumes nothing beyond a SystemVerilog compiler.
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  typedef struct packed {
    logic ovf_b;
    logic ovf_a;
    logic ext_b;
    logic ext_a;
  } irq_flags_t;

  function automatic mode_t decode_mode(input logic [1:0] sel);
    mode_t m;
    m = MODE_13BIT;
    unique case (sel)
      2'h0: m = MODE_13BIT;
      2'h1: m = MODE_16BIT;
      2'h2: m = MODE_RELOAD8;
      2'h3: m = MODE_SPLIT;
    endcase
    return m;
  endfunction : decode_mode

endpackage : timer_pkg

// File: hdl/timer_channel.sv
// One timer/counter channel: low and high count registers, mode-dependent increment and rollover.
// Assumes a one-cycle count enable and register write strobes on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"

module timer_channel (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            count_en,
  input  wire logic            wr_low,
  input  wire logic            wr_high,
  input  wire logic [7:0]      wdata,
  input  wire timer_pkg::mode_t mode,
  output logic      [7:0]      count_low,
  output logic      [7:0]      count_high,
  output logic                 rollover
);

  logic [7:0] low_reg;
  logic [7:0] high_reg;
  logic [7:0] low_next;
  logic [7:0] high_next;

  wire full13 = (high_reg == 8'hFF) && (low_reg[4:0] == 5'h1F);
  wire full16 = (high_reg == 8'hFF) && (low_reg == 8'hFF);
  wire full8  = (low_reg == 8'hFF);
  wire step   = count_en && !wr_low && !wr_high;

  // Rollover on increment from the mode's all-ones count, except in split mode, which never rolls over
  always_comb begin
    rollover = 1'b0;
    unique case (mode)
      timer_pkg::MODE_13BIT:   rollover = step && full13;
      timer_pkg::MODE_16BIT:   rollover = step && full16;
      timer_pkg::MODE_RELOAD8: rollover = step && full8;
      timer_pkg::MODE_SPLIT:   rollover = 1'b0;
    endcase
  end

  always_comb begin
    low_next  = low_reg;
    high_next = high_reg;
    if (step) begin
      unique case (mode)
        timer_pkg::MODE_13BIT: begin
          low_next[4:0] = low_reg[4:0] + 5'h01;
          if (low_reg[4:0] == 5'h1F) begin
            high_next = high_reg + 8'h01;
          end
        end
        timer_pkg::MODE_16BIT: begin
          low_next = low_reg + 8'h01;
          if (full8) begin
            high_next = high_reg + 8'h01;
          end
        end
        timer_pkg::MODE_RELOAD8: begin
          low_next = full8 ? high_reg : low_reg + 8'h01;
        end
        timer_pkg::MODE_SPLIT: begin
          low_next = low_reg;
        end
      endcase
    end
    if (wr_low) begin
      low_next = wdata;
    end
    if (wr_high) begin
      high_next = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_reg  <= `TMR_COUNT_RESET;
      high_reg <= `TMR_COUNT_RESET;
    end else begin
      low_reg  <= low_next;
      high_reg <= high_next;
    end
  end

  assign count_low  = low_reg;
  assign count_high = high_reg;

endmodule : timer_channel

`default_nettype wire

// File: hdl/dual_timer_counter.sv
// Two timer/counters with their overflow and external interrupt flags, behind special-function registers.
// Assumes the core's register port and vector acknowledges run on clk; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"

module dual_timer_counter #(
  parameter int DIV_SLOW = `TMR_DIV_SLOW,
  parameter int DIV_FAST = `TMR_DIV_FAST
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire timer_pkg::sfr_req_t   sfr_req,
  output logic [7:0]                 sfr_rdata,
  input  wire timer_pkg::irq_flags_t vector_ack,
  output timer_pkg::irq_flags_t      irq_flags,
  input  wire logic                  ext_irq_pin_a_n,
  input  wire logic                  ext_irq_pin_b_n,
  input  wire logic                  count_pin_a,
  input  wire logic                  count_pin_b,
  output logic                       overflow_pulse_a,
  output logic                       overflow_pulse_b
);

  if (DIV_FAST < 1 || DIV_SLOW <= DIV_FAST || DIV_SLOW > 255 || (DIV_SLOW % DIV_FAST) != 0) begin : gen_bad_div
    $error("dual_timer_counter: unsupported divider settings");
  end

  localparam logic [7:0] SLOW_LAST = 8'(DIV_SLOW - 1);
  localparam logic [7:0] FAST_MOD  = 8'(DIV_FAST);

  // Flag update: hardware set wins over software write and vector clear
  function automatic logic sticky_next(input logic flag, input logic set, input logic wr,
                                       input logic wbit, input logic ack);
    return set | (wr ? wbit : (flag & ~ack));
  endfunction : sticky_next

  // Reset release
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Pin synchronisers: 0 irq a, 1 irq b, 2 count a, 3 count b
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] level_reg;
  wire  [3:0] pins       = {count_pin_b, count_pin_a, ext_irq_pin_b_n, ext_irq_pin_a_n};
  wire  [3:0] agree      = ~(sync2_reg ^ sync3_reg);
  wire  [3:0] level_next = (agree & sync3_reg) | (~agree & level_reg);
  wire  [3:0] fall       = level_reg & ~level_next;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      sync3_reg <= 4'hF;
      level_reg <= 4'hF;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
    end
  end

  // Clock prescaler
  logic [7:0] presc_reg;
  wire        tick_slow = (presc_reg == SLOW_LAST);
  wire        tick_fast = ((8'(presc_reg + 8'h01) % FAST_MOD) == 8'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= 8'h00;
    end else begin
      presc_reg <= tick_slow ? 8'h00 : presc_reg + 8'h01;
    end
  end

  // Registers
  logic [7:0] ctrl_reg;
  logic [7:0] mode_reg;
  logic [7:0] rate_reg;
  logic [7:0] rdata_reg;
  logic       pulse_a_reg;
  logic       pulse_b_reg;

  wire wr_ctrl   = sfr_req.wr && (sfr_req.addr == `TMR_CTRL_ADDR);
  wire wr_mode   = sfr_req.wr && (sfr_req.addr == `TMR_MODE_ADDR);
  wire wr_rate   = sfr_req.wr && (sfr_req.addr == `TMR_RATE_ADDR);
  wire wr_low_a  = sfr_req.wr && (sfr_req.addr == `TMR_LOW_A_ADDR);
  wire wr_low_b  = sfr_req.wr && (sfr_req.addr == `TMR_LOW_B_ADDR);
  wire wr_high_a = sfr_req.wr && (sfr_req.addr == `TMR_HIGH_A_ADDR);
  wire wr_high_b = sfr_req.wr && (sfr_req.addr == `TMR_HIGH_B_ADDR);

  wire run_a  = ctrl_reg[`CTRL_RUN_A];
  wire run_b  = ctrl_reg[`CTRL_RUN_B];
  wire type_a = ctrl_reg[`CTRL_TYPE_A];
  wire type_b = ctrl_reg[`CTRL_TYPE_B];

  timer_pkg::mode_t mode_a;
  timer_pkg::mode_t mode_b;
  assign mode_a = timer_pkg::decode_mode(mode_reg[`MODE_SEL_A_HI:`MODE_SEL_A_LO]);
  assign mode_b = timer_pkg::decode_mode(mode_reg[`MODE_SEL_B_HI:`MODE_SEL_B_LO]);

  // Count enables
  wire gate_ok_a = !mode_reg[`MODE_GATE_A] || level_reg[0];
  wire gate_ok_b = !mode_reg[`MODE_GATE_B] || level_reg[1];
  wire tick_a    = rate_reg[`RATE_SEL_A] ? tick_fast : tick_slow;
  wire tick_b    = rate_reg[`RATE_SEL_B] ? tick_fast : tick_slow;
  wire src_a     = mode_reg[`MODE_CT_A] ? fall[2] : tick_a;
  wire src_b     = mode_reg[`MODE_CT_B] ? fall[3] : tick_b;
  wire inc_a     = run_a && gate_ok_a && src_a;
  wire inc_b     = run_b && gate_ok_b && src_b;

  logic [7:0] low_a;
  logic [7:0] high_a;
  logic [7:0] low_b;
  logic [7:0] high_b;
  logic       roll_a;
  logic       roll_b;

  timer_channel u_chan_a (
    .clk        (clk),
    .rst_n      (rst_n),
    .count_en   (inc_a),
    .wr_low     (wr_low_a),
    .wr_high    (wr_high_a),
    .wdata      (sfr_req.wdata),
    .mode       (mode_a),
    .count_low  (low_a),
    .count_high (high_a),
    .rollover   (roll_a)
  );

  timer_channel u_chan_b (
    .clk        (clk),
    .rst_n      (rst_n),
    .count_en   (inc_b),
    .wr_low     (wr_low_b),
    .wr_high    (wr_high_b),
    .wdata      (sfr_req.wdata),
    .mode       (mode_b),
    .count_low  (low_b),
    .count_high (high_b),
    .rollover   (roll_b)
  );

  // Flag next values
  wire ovf_b_next = sticky_next(ctrl_reg[`CTRL_OVF_B], roll_b, wr_ctrl,
                                sfr_req.wdata[`CTRL_OVF_B], vector_ack.ovf_b);
  wire ovf_a_next = sticky_next(ctrl_reg[`CTRL_OVF_A], roll_a, wr_ctrl,
                                sfr_req.wdata[`CTRL_OVF_A], vector_ack.ovf_a);
  wire ext_b_edge = sticky_next(ctrl_reg[`CTRL_EXT_B], fall[1], wr_ctrl,
                                sfr_req.wdata[`CTRL_EXT_B], vector_ack.ext_b);
  wire ext_a_edge = sticky_next(ctrl_reg[`CTRL_EXT_A], fall[0], wr_ctrl,
                                sfr_req.wdata[`CTRL_EXT_A], vector_ack.ext_a);
  wire ext_b_next = type_b ? ext_b_edge : !level_reg[1];
  wire ext_a_next = type_a ? ext_a_edge : !level_reg[0];

  wire [7:0] ctrl_next = {ovf_b_next,
                          wr_ctrl ? sfr_req.wdata[`CTRL_RUN_B] : run_b,
                          ovf_a_next,
                          wr_ctrl ? sfr_req.wdata[`CTRL_RUN_A] : run_a,
                          ext_b_next,
                          wr_ctrl ? sfr_req.wdata[`CTRL_TYPE_B] : type_b,
                          ext_a_next,
                          wr_ctrl ? sfr_req.wdata[`CTRL_TYPE_A] : type_a};

  // Read mux, unmapped offsets read zero
  wire [7:0] rd_mux = (sfr_req.addr == `TMR_CTRL_ADDR)   ? ctrl_reg :
                      (sfr_req.addr == `TMR_MODE_ADDR)   ? mode_reg :
                      (sfr_req.addr == `TMR_RATE_ADDR)   ? rate_reg :
                      (sfr_req.addr == `TMR_LOW_A_ADDR)  ? low_a :
                      (sfr_req.addr == `TMR_LOW_B_ADDR)  ? low_b :
                      (sfr_req.addr == `TMR_HIGH_A_ADDR) ? high_a :
                      (sfr_req.addr == `TMR_HIGH_B_ADDR) ? high_b : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg    <= `TMR_CTRL_RESET;
      mode_reg    <= `TMR_MODE_RESET;
      rate_reg    <= `TMR_RATE_RESET;
      rdata_reg   <= 8'h00;
      pulse_a_reg <= 1'b0;
      pulse_b_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      mode_reg    <= wr_mode ? sfr_req.wdata : mode_reg;
      rate_reg    <= wr_rate ? sfr_req.wdata : rate_reg;
      rdata_reg   <= sfr_req.rd ? rd_mux : rdata_reg;
      pulse_a_reg <= roll_a;
      pulse_b_reg <= roll_b;
    end
  end

  assign sfr_rdata        = rdata_reg;
  assign overflow_pulse_a = pulse_a_reg;
  assign overflow_pulse_b = pulse_b_reg;
  assign irq_flags        = '{ovf_b: ctrl_reg[`CTRL_OVF_B], ovf_a: ctrl_reg[`CTRL_OVF_A],
                              ext_b: ctrl_reg[`CTRL_EXT_B], ext_a: ctrl_reg[`CTRL_EXT_A]};

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_pulse_a_once;
    overflow_pulse_a ##1 !overflow_pulse_a;
  endsequence

  sequence seq_pulse_b_once;
    overflow_pulse_b ##1 !overflow_pulse_b;
  endsequence

  chk_ovf_b_set: assert property (roll_b |=> irq_flags.ovf_b)
    else $error("timer b rollover did not set its flag");
  chk_ovf_a_set: assert property (roll_a |=> irq_flags.ovf_a)
    else $error("timer a rollover did not set its flag");
  chk_run_hold: assert property (!run_a && !wr_low_a && !wr_high_a |=> $stable({high_a, low_a}))
    else $error("stopped timer a changed its count");
  chk_edge_flag: assert property (type_a && fall[0] && !wr_ctrl |=> irq_flags.ext_a)
    else $error("falling edge did not set irq flag a");
  chk_level_follow: assert property (!type_b ##1 !type_b |-> irq_flags.ext_b == !$past(level_reg[1]))
    else $error("level flag b does not follow its pin");
  chk_gate_block: assert property (mode_reg[`MODE_GATE_A] && !level_reg[0] && !wr_low_a && !wr_high_a
                                   |=> $stable({high_a, low_a}))
    else $error("gated timer a counted while pin low");
  chk_wrap_13: assert property (mode_a == timer_pkg::MODE_13BIT && roll_a
                                |=> high_a == 8'h00 && low_a[4:0] == 5'h00)
    else $error("13-bit count did not wrap to zero");
  chk_reload_val: assert property (mode_b == timer_pkg::MODE_RELOAD8 && roll_b |=> low_b == $past(high_b))
    else $error("8-bit count did not reload from high register");
  chk_pulse_width: assert property (roll_a |=> seq_pulse_a_once)
    else $error("overflow pulse a not exactly one clock");
  chk_pulse_b_width: assert property (roll_b |=> seq_pulse_b_once)
    else $error("overflow pulse b not exactly one clock");
  chk_slow_rate: assert property (!mode_reg[`MODE_CT_B] && !rate_reg[`RATE_SEL_B] && inc_b
                                  |-> presc_reg == SLOW_LAST)
    else $error("timer b stepped off the slow prescaler tick");

endmodule : dual_timer_counter

`default_nettype wire

// File: testbench/core_model.sv
// Processor core model: register reads, register writes and vector acknowledges.
// Assumes a registered read port and one-cycle strobes taken on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input  wire logic            clk,
  input  wire logic [7:0]      sfr_rdata,
  output timer_pkg::sfr_req_t   sfr_req,
  output timer_pkg::irq_flags_t vector_ack
);
  initial begin
    sfr_req = '0;
    vector_ack = '0;
  end

  // Write strobe held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) #1;
    sfr_req.wr = 1'b0;
  endtask : wr

  // Read data taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) #1;
    sfr_req.rd = 1'b0;
    d = sfr_rdata;
  endtask : rd

  // One-cycle vector acknowledge
  task automatic ack(input logic [3:0] f);
    @(posedge clk) #1;
    vector_ack = timer_pkg::irq_flags_t'(f);
    @(posedge clk) #1;
    vector_ack = '0;
  endtask : ack
endmodule : core_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench of the dual timer/counter: registers, modes, rates, pins and flags.
// Assumes hdl/ on the include path and the core model on the register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %0t mismatch line %0d got %h expected %h", $time, `__LINE__, got, exp); end end

module tb;
  localparam int DIV_SLOW = 12;
  localparam int DIV_FAST = 4;
  logic                  clk;
  logic                  reset_n;
  logic                  ext_irq_pin_a_n;
  logic                  ext_irq_pin_b_n;
  logic                  count_pin_a;
  logic                  count_pin_b;
  logic [7:0]            sfr_rdata;
  logic                  overflow_pulse_a;
  logic                  overflow_pulse_b;
  timer_pkg::sfr_req_t   sfr_req;
  timer_pkg::irq_flags_t vector_ack;
  timer_pkg::irq_flags_t irq_flags;
  int                    failures;
  int                    check_count;
  int                    cycles;
  int                    n;
  logic [7:0]            rv;

  dual_timer_counter #(.DIV_SLOW(DIV_SLOW), .DIV_FAST(DIV_FAST)) dut_u (
    .clk(clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .vector_ack(vector_ack), .irq_flags(irq_flags),
    .ext_irq_pin_a_n(ext_irq_pin_a_n), .ext_irq_pin_b_n(ext_irq_pin_b_n),
    .count_pin_a(count_pin_a), .count_pin_b(count_pin_b),
    .overflow_pulse_a(overflow_pulse_a), .overflow_pulse_b(overflow_pulse_b)
  );

  core_model core_u (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req), .vector_ack(vector_ack));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : idle

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    core_u.rd(a, rv);
    `CHK(rv, e)
  endtask : rd_chk

  task automatic wait_pulse(input logic b, output int k);
    k = 0;
    do begin
      @(posedge clk) #1;
      k++;
    end while ((b ? overflow_pulse_b : overflow_pulse_a) !== 1'b1 && k < 2000);
  endtask : wait_pulse

  task automatic fall_pin;
    count_pin_a = 1'b0;
    idle(6);
    count_pin_a = 1'b1;
    idle(6);
  endtask : fall_pin

  task automatic test_reset;
    rd_chk(`TMR_CTRL_ADDR, `TMR_CTRL_RESET);
    rd_chk(`TMR_MODE_ADDR, `TMR_MODE_RESET);
    rd_chk(`TMR_RATE_ADDR, `TMR_RATE_RESET);
    for (int i = 0; i < 4; i++) begin
      rd_chk(`TMR_LOW_A_ADDR + 8'(i), `TMR_COUNT_RESET);
    end
    core_u.wr(8'h8F, 8'hFF);
    rd_chk(8'h8F, 8'h00);
  endtask : test_reset

  task automatic test_mode1_a;
    core_u.wr(`TMR_RATE_ADDR, 8'h09);
    core_u.wr(`TMR_MODE_ADDR, 8'h01);
    core_u.wr(`TMR_LOW_A_ADDR, 8'hFF);
    core_u.wr(`TMR_HIGH_A_ADDR, 8'hFF);
    idle(20);
    rd_chk(`TMR_LOW_A_ADDR, 8'hFF);
    core_u.wr(`TMR_CTRL_ADDR, 8'h10);
    wait_pulse(1'b0, n);
    `CHK(overflow_pulse_a, 1'b1)
    `CHK(irq_flags.ovf_a, 1'b1)
    idle(1);
    `CHK(overflow_pulse_a, 1'b0)
    rd_chk(`TMR_CTRL_ADDR, 8'h30);
    core_u.ack(4'b0100);
    `CHK(irq_flags.ovf_a, 1'b0)
    rd_chk(`TMR_HIGH_A_ADDR, 8'h00);
    core_u.wr(`TMR_CTRL_ADDR, 8'h00);
  endtask : test_mode1_a

  task automatic test_mode0_b;
    core_u.wr(`TMR_RATE_ADDR, 8'h01);
    core_u.wr(`TMR_MODE_ADDR, 8'h00);
    core_u.wr(`TMR_LOW_B_ADDR, 8'h3F);
    core_u.wr(`TMR_HIGH_B_ADDR, 8'hFF);
    core_u.wr(`TMR_CTRL_ADDR, 8'h40);
    wait_pulse(1'b1, n);
    `CHK(overflow_pulse_b, 1'b1)
    `CHK(n <= DIV_SLOW + 4, 1'b1)
    `CHK(irq_flags.ovf_b, 1'b1)
    idle(1);
    `CHK(overflow_pulse_b, 1'b0)
    core_u.ack(4'b1000);
    `CHK(irq_flags.ovf_b, 1'b0)
    core_u.wr(`TMR_CTRL_ADDR, 8'h00);
    rd_chk(`TMR_HIGH_B_ADDR, 8'h00);
    core_u.rd(`TMR_LOW_B_ADDR, rv);
    `CHK(rv & 8'h1F, 8'h00)
  endtask : test_mode0_b

  task automatic test_mode2_a;
    core_u.wr(`TMR_MODE_ADDR, 8'h02);
    core_u.wr(`TMR_HIGH_A_ADDR, 8'hFE);
    core_u.wr(`TMR_LOW_A_ADDR, 8'hFE);
    core_u.wr(`TMR_CTRL_ADDR, 8'h10);
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    `CHK(n, 2 * DIV_SLOW)
    core_u.wr(`TMR_RATE_ADDR, 8'h09);
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    `CHK(n, 2 * DIV_FAST)
    `CHK(irq_flags.ovf_a, 1'b1)
    core_u.rd(`TMR_LOW_A_ADDR, rv);
    `CHK(rv[7:1], 7'h7F)
    core_u.wr(`TMR_CTRL_ADDR, 8'h00);
  endtask : test_mode2_a

  task automatic test_counter_gate;
    core_u.wr(`TMR_MODE_ADDR, 8'h05);
    core_u.wr(`TMR_LOW_A_ADDR, 8'h00);
    core_u.wr(`TMR_HIGH_A_ADDR, 8'h00);
    core_u.wr(`TMR_CTRL_ADDR, 8'h10);
    repeat (3) fall_pin();
    rd_chk(`TMR_LOW_A_ADDR, 8'h03);
    core_u.wr(`TMR_MODE_ADDR, 8'h0D);
    ext_irq_pin_a_n = 1'b0;
    idle(8);
    `CHK(irq_flags.ext_a, 1'b1)
    core_u.wr(`TMR_CTRL_ADDR, 8'h10);
    `CHK(irq_flags.ext_a, 1'b1)
    fall_pin();
    rd_chk(`TMR_LOW_A_ADDR, 8'h03);
    ext_irq_pin_a_n = 1'b1;
    idle(8);
    `CHK(irq_flags.ext_a, 1'b0)
    fall_pin();
    rd_chk(`TMR_LOW_A_ADDR, 8'h04);
    core_u.wr(`TMR_CTRL_ADDR, 8'h00);
    fall_pin();
    rd_chk(`TMR_LOW_A_ADDR, 8'h04);
  endtask : test_counter_gate

  task automatic test_edge_b;
    core_u.wr(`TMR_CTRL_ADDR, 8'h04);
    ext_irq_pin_b_n = 1'b0;
    idle(8);
    `CHK(irq_flags.ext_b, 1'b1)
    ext_irq_pin_b_n = 1'b1;
    idle(8);
    `CHK(irq_flags.ext_b, 1'b1)
    core_u.ack(4'b0010);
    `CHK(irq_flags.ext_b, 1'b0)
    ext_irq_pin_b_n = 1'b0;
    idle(8);
    rd_chk(`TMR_CTRL_ADDR, 8'h0C);
    core_u.wr(`TMR_CTRL_ADDR, 8'h04);
    `CHK(irq_flags.ext_b, 1'b0)
    core_u.wr(`TMR_CTRL_ADDR, 8'h00);
    idle(8);
    `CHK(irq_flags.ext_b, 1'b1)
    core_u.ack(4'b0010);
    `CHK(irq_flags.ext_b, 1'b1)
    ext_irq_pin_b_n = 1'b1;
    idle(8);
  endtask : test_edge_b

  task automatic test_cross;
    logic [7:0] held;
    core_u.wr(`TMR_RATE_ADDR, 8'h11);
    core_u.wr(`TMR_MODE_ADDR, 8'h20);
    core_u.wr(`TMR_LOW_A_ADDR, 8'h1F);
    core_u.wr(`TMR_HIGH_A_ADDR, 8'hFF);
    core_u.wr(`TMR_LOW_B_ADDR, 8'hFF);
    core_u.wr(`TMR_HIGH_B_ADDR, 8'h80);
    core_u.wr(`TMR_CTRL_ADDR, 8'h51);
    wait_pulse(1'b0, n);
    `CHK(n <= DIV_SLOW, 1'b1)
    `CHK(irq_flags.ovf_a, 1'b1)
    rd_chk(`TMR_HIGH_A_ADDR, 8'h00);
    wait_pulse(1'b1, n);
    wait_pulse(1'b1, n);
    `CHK(n, 128 * DIV_FAST)
    rd_chk(`TMR_LOW_B_ADDR, 8'h80);
    ext_irq_pin_a_n = 1'b0;
    idle(8);
    `CHK(irq_flags.ext_a, 1'b1)
    ext_irq_pin_a_n = 1'b1;
    idle(8);
    `CHK(irq_flags.ext_a, 1'b1)
    core_u.ack(4'b0001);
    `CHK(irq_flags.ext_a, 1'b0)
    core_u.wr(`TMR_MODE_ADDR, 8'h33);
    core_u.rd(`TMR_LOW_B_ADDR, held);
    idle(30);
    rd_chk(`TMR_LOW_B_ADDR, held);
    core_u.wr(`TMR_MODE_ADDR, 8'h50);
    core_u.wr(`TMR_LOW_B_ADDR, 8'h00);
    count_pin_b = 1'b0;
    idle(6);
    count_pin_b = 1'b1;
    idle(6);
    rd_chk(`TMR_LOW_B_ADDR, 8'h01);
    core_u.wr(`TMR_CTRL_ADDR, 8'h00);
  endtask : test_cross

  initial begin
    reset_n = 1'b0;
    ext_irq_pin_a_n = 1'b1;
    ext_irq_pin_b_n = 1'b1;
    count_pin_a = 1'b1;
    count_pin_b = 1'b1;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    idle(4);
    test_reset();
    test_mode1_a();
    test_mode0_b();
    test_mode2_a();
    test_counter_gate();
    test_edge_b();
    test_cross();
    finish_test();
  end
endmodule : tb
`default_nettype wire
